// >>> verilog/ssa_pkg.sv
// constants, codes and types of the spd eeprom serial access block
package ssa_pkg;

    // ========================================
    // address byte codes
    localparam logic [3:0] MEM_TYPE   = 4'ha;   // normal memory device type
    localparam logic [3:0] CTL_TYPE   = 4'h6;   // bank and protect commands
    localparam logic [2:0] SEL_BANK0  = 3'h6;   // select bank zero / query
    localparam logic [2:0] SEL_BANK1  = 3'h7;   // select bank one
    localparam logic [2:0] SEL_CLR    = 3'h3;   // clear all protection
    localparam logic [2:0] SEL_BLK0   = 3'h1;
    localparam logic [2:0] SEL_BLK1   = 3'h4;
    localparam logic [2:0] SEL_BLK2   = 3'h5;
    localparam logic [2:0] SEL_BLK3   = 3'h0;

    // ========================================
    // memory organisation
    localparam int PAGE_BYTES = 16;
    localparam int PAGE_AW    = 4;
    localparam int MEM_BYTES  = 512;
    localparam int MEM_AW     = 9;
    localparam int NUM_BLOCKS = 4;
    localparam logic [3:0] BIT_ACK  = 4'h8;     // bit count at the ack slot
    localparam logic       BANK_RST = 1'b0;     // bank after reset

    // ========================================
    // timing
    localparam int SYS_CLK_NS      = 40;
    localparam int WRITE_CYCLE_NS  = 3000000;
    localparam int WRITE_CYCLE_CYC =
        (WRITE_CYCLE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

    // ========================================
    // types
    typedef enum logic [1:0] {
        OP_NONE  = 2'h0,
        OP_WRITE = 2'h1,
        OP_SET   = 2'h2,
        OP_CLR   = 2'h3
    } ssa_op_e;

    typedef enum logic [5:0] {
        S_IDLE   = 6'h01,
        S_DEV    = 6'h02,
        S_WORD   = 6'h04,
        S_DATA   = 6'h08,
        S_ACKALL = 6'h10,
        S_NAKALL = 6'h20
    } ssa_state_e;

    // block command select bits to {valid, block index}
    function automatic logic [2:0] ssa_blk_of_sel(input logic [2:0] sel);
        case (sel)
            SEL_BLK0: ssa_blk_of_sel = 3'h4;
            SEL_BLK1: ssa_blk_of_sel = 3'h5;
            SEL_BLK2: ssa_blk_of_sel = 3'h6;
            SEL_BLK3: ssa_blk_of_sel = 3'h7;
            default:  ssa_blk_of_sel = 3'h0;
        endcase
    endfunction

endpackage

// >>> verilog/ssa_spd_eeprom.sv
// spd eeprom two-wire target: writes, bank select, block protection
// Operation
// - device address then word address loads pointer; next byte goes there
// - up to fifteen more data bytes are buffered until stop
// - each data byte bumps only the low four pointer bits
// - over sixteen bytes wrap in the page and overwrite earlier ones
// - nonvolatile write cycle starts only after stop
// - page write past page end continues at same page start
// - two banks of 256 bytes, word address indexes selected bank
// - command 6c selects bank zero, 6e bank one, both acknowledged
// - bank query acknowledges for bank zero, not for bank one
// - bank commands ignore the address pins and the first pin level
// - four 128-byte blocks each with own protect state
// - protect commands use type 0110 and ignore address pins
// - writes to protected block are not acknowledged and not stored
// - set-protect only while high voltage is detected
// - protection holds until clear-protect command
// - a status query exists for every block
// - status query acknowledges unprotected, not acknowledges protected
// - clear-protect is 0110 select 011 write with high voltage, all blocks
// - protect set and clear act only after the stop
`timescale 1ns/1ps
`default_nettype none
module ssa_spd_eeprom
    import ssa_pkg::*;
#(
    parameter int unsigned WR_CYC = WRITE_CYCLE_CYC
)(
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    input  wire logic              lnk_clk,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe,
    input  wire logic              high_voltage_level,
    input  wire logic              addr_pin_zero,
    input  wire logic              addr_pin_one,
    input  wire logic              addr_pin_two,
    input  wire logic [MEM_AW-1:0] mem_rd_addr,
    output logic [7:0]             mem_rd_data,
    output logic                   wr_busy
);

    localparam int WCW = $clog2(WR_CYC + 1);

    // ========================================
    // link domain: reset release and pin synchronisers
    logic       lrst_m, lrst_q;
    logic       scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
    logic       hv_m, hv_s;
    logic [2:0] pins_m, pins_s;
    logic [3:0] prot_m, prot_s;
    logic       ack_m, ack_s;
    // driven by the system side, declared here because this side reads them
    logic                  ack_tgl_q;
    // power-up value only, reset leaves the cells alone
    logic [NUM_BLOCKS-1:0] prot_q = '0;

    // reset leaves each domain only on its own clock edge
    always_ff @(posedge lnk_clk or negedge rst_b) begin
        if (!rst_b) begin
            lrst_m <= 1'b0;
            lrst_q <= 1'b0;
        end else begin
            lrst_m <= 1'b1;
            lrst_q <= lrst_m;
        end
    end

    // two flops per pin; a third copy of scl and sda gives edges
    always_ff @(posedge lnk_clk or negedge lrst_q) begin
        if (!lrst_q) begin
            {scl_m, scl_s, scl_p} <= 3'h7;
            {sda_m, sda_s, sda_p} <= 3'h7;
            {hv_m, hv_s}          <= 2'h0;
            pins_m                <= 3'h0;
            pins_s                <= 3'h0;
        end else begin
            {scl_m, scl_s, scl_p} <= {scl_in, scl_m, scl_s};
            {sda_m, sda_s, sda_p} <= {sda_in, sda_m, sda_s};
            {hv_m, hv_s}          <= {high_voltage_level, hv_m};
            pins_m <= {addr_pin_two, addr_pin_one, addr_pin_zero};
            pins_s <= pins_m;
        end
    end

    logic scl_rise, scl_fall, start_det, stop_det, byte_done;
    assign scl_rise  = scl_s & ~scl_p;
    assign scl_fall  = ~scl_s & scl_p;
    assign start_det = scl_s & scl_p & sda_p & ~sda_s;
    assign stop_det  = scl_s & scl_p & ~sda_p & sda_s;

    // ========================================
    // bit shifter
    logic [3:0] bcnt_q;
    logic [7:0] sh_q;
    assign byte_done = scl_fall & (bcnt_q == BIT_ACK);

    // eight data bits then the ack clock, which resets the count
    always_ff @(posedge lnk_clk or negedge lrst_q) begin
        if (!lrst_q) begin
            bcnt_q <= 4'h0;
            sh_q   <= 8'h00;
        end else if (start_det) begin
            bcnt_q <= 4'h0;
        end else if (scl_rise) begin
            if (bcnt_q == BIT_ACK) begin
                bcnt_q <= 4'h0;
            end else begin
                sh_q   <= {sh_q[6:0], sda_s};
                bcnt_q <= bcnt_q + 4'h1;
            end
        end
    end

    // ========================================
    // command decode
    ssa_state_e st_q, nxt_st;
    ssa_op_e    pend_q, pend_v, cmt_op_q;
    logic       bank_q, bank_we, bank_v;
    logic [7:0] ptr_q;
    logic       ack_d, ptr_ld, store, pend_we, busy;
    logic       req_tgl_q;
    logic [2:0] blk;
    logic [1:0] pend_blk_q, cmt_blk_q;

    assign blk  = ssa_blk_of_sel(sh_q[3:1]);
    // busy from write start until the memory side hands back its toggle
    assign busy = req_tgl_q ^ ack_s;

    always_comb begin
        nxt_st  = st_q;
        ack_d   = 1'b0;
        bank_we = 1'b0;
        bank_v  = bank_q;
        ptr_ld  = 1'b0;
        store   = 1'b0;
        pend_we = 1'b0;
        pend_v  = OP_NONE;
        case (st_q)
            S_DEV: begin
                nxt_st = S_NAKALL;
                if (sh_q[7:4] == MEM_TYPE && sh_q[3:1] == pins_s
                    && !sh_q[0] && !busy) begin
                    ack_d  = 1'b1;
                    nxt_st = S_WORD;
                end else if (sh_q[7:4] == CTL_TYPE) begin
                    if (sh_q[3:1] == SEL_BANK0 && sh_q[0]) begin
                        ack_d = ~bank_q;
                    end else if (sh_q[3:2] == SEL_BANK0[2:1]) begin
                        ack_d   = 1'b1;
                        bank_we = 1'b1;
                        bank_v  = sh_q[1];
                        nxt_st  = S_ACKALL;
                    end else if (blk[2] && sh_q[0]) begin
                        ack_d = ~prot_s[blk[1:0]];
                    end else if (blk[2] && hv_s && !busy
                                 && !prot_s[blk[1:0]]) begin
                        ack_d   = 1'b1;
                        pend_we = 1'b1;
                        pend_v  = OP_SET;
                        nxt_st  = S_ACKALL;
                    end else if (sh_q[3:1] == SEL_CLR && !sh_q[0]
                                 && hv_s && !busy) begin
                        ack_d   = 1'b1;
                        pend_we = 1'b1;
                        pend_v  = OP_CLR;
                        nxt_st  = S_ACKALL;
                    end
                end
            end
            S_WORD: begin
                ack_d  = 1'b1;
                ptr_ld = 1'b1;
                nxt_st = S_DATA;
            end
            S_DATA: begin
                if (prot_s[{bank_q, ptr_q[7]}]) begin
                    nxt_st  = S_NAKALL;
                    pend_we = 1'b1;
                    pend_v  = OP_NONE;
                end else begin
                    ack_d   = 1'b1;
                    store   = 1'b1;
                    pend_we = 1'b1;
                    pend_v  = OP_WRITE;
                end
            end
            S_ACKALL: ack_d = 1'b1;
            default: ;
        endcase
    end

    // transaction state: start opens, stop closes
    always_ff @(posedge lnk_clk or negedge lrst_q) begin
        if (!lrst_q) begin
            st_q <= S_IDLE;
        end else if (start_det) begin
            st_q <= S_DEV;
        end else if (stop_det) begin
            st_q <= S_IDLE;
        end else if (byte_done) begin
            st_q <= nxt_st;
        end
    end

    // ack driven from the fall after bit eight to the fall after the ack
    always_ff @(posedge lnk_clk or negedge lrst_q) begin
        if (!lrst_q) begin
            sda_oe  <= 1'b0;
            sda_out <= 1'b0;
        end else if (start_det || stop_det) begin
            sda_oe <= 1'b0;
        end else if (byte_done) begin
            sda_oe <= ack_d;
        end else if (scl_fall && bcnt_q == 4'h0) begin
            sda_oe <= 1'b0;
        end
    end

    always_ff @(posedge lnk_clk or negedge lrst_q) begin
        if (!lrst_q) begin
            bank_q <= BANK_RST;
        end else if (byte_done && bank_we) begin
            bank_q <= bank_v;
        end
    end

    // ========================================
    // pointer and page buffer
    logic [7:0]            pbuf_q [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] mask_q;

    // only low nibble advances, so the page wraps
    always_ff @(posedge lnk_clk or negedge lrst_q) begin
        if (!lrst_q) begin
            ptr_q <= 8'h00;
        end else if (byte_done && ptr_ld) begin
            ptr_q <= sh_q;
        end else if (byte_done && store) begin
            ptr_q <= {ptr_q[7:4], ptr_q[3:0] + 4'h1};
        end
    end

    always_ff @(posedge lnk_clk) begin
        if (byte_done && store) begin
            pbuf_q[ptr_q[PAGE_AW-1:0]] <= sh_q;
        end
    end

    always_ff @(posedge lnk_clk or negedge lrst_q) begin
        if (!lrst_q) begin
            mask_q <= '0;
        end else if (byte_done && ptr_ld) begin
            mask_q <= '0;
        end else if (byte_done && store) begin
            mask_q[ptr_q[PAGE_AW-1:0]] <= 1'b1;
        end
    end

    // ========================================
    // pending operation and hand-off to the memory side
    logic [MEM_AW-PAGE_AW-1:0] cmt_page_q;

    // a repeated start drops anything not yet committed
    always_ff @(posedge lnk_clk or negedge lrst_q) begin
        if (!lrst_q) begin
            pend_q     <= OP_NONE;
            pend_blk_q <= 2'h0;
        end else if (start_det || stop_det) begin
            pend_q <= OP_NONE;
        end else if (byte_done && pend_we) begin
            pend_q     <= pend_v;
            pend_blk_q <= blk[1:0];
        end
    end

    // protect changes wait for stop
    // words stay still while busy, so the other side reads them directly
    always_ff @(posedge lnk_clk or negedge lrst_q) begin
        if (!lrst_q) begin
            req_tgl_q  <= 1'b0;
            cmt_op_q   <= OP_NONE;
            cmt_blk_q  <= 2'h0;
            cmt_page_q <= '0;
        end else if (stop_det && pend_q != OP_NONE && !busy) begin
            req_tgl_q  <= ~req_tgl_q;
            cmt_op_q   <= pend_q;
            cmt_blk_q  <= pend_blk_q;
            cmt_page_q <= {bank_q, ptr_q[7:4]};
        end
    end

    // memory side answers back into the link domain
    always_ff @(posedge lnk_clk or negedge lrst_q) begin
        if (!lrst_q) begin
            {ack_m, ack_s}   <= 2'h0;
            {prot_m, prot_s} <= 8'h00;
        end else begin
            {ack_m, ack_s}   <= {ack_tgl_q, ack_m};
            {prot_m, prot_s} <= {prot_q, prot_m};
        end
    end

    // ========================================
    // system domain: write cycle and nonvolatile store
    logic                  srst_m, srst_q;
    logic                  req_m, req_s, req_p, active_q;
    logic [WCW-1:0]        wcnt_q;
    logic [7:0]            mem_q [MEM_BYTES];
    logic                  req_ev, cyc_end;

    assign req_ev  = req_s ^ req_p;
    assign cyc_end = active_q && wcnt_q == WCW'(WR_CYC - 1);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            srst_m <= 1'b0;
            srst_q <= 1'b0;
        end else begin
            srst_m <= 1'b1;
            srst_q <= srst_m;
        end
    end

    // cycle timer; the copy runs in the first sixteen counts
    always_ff @(posedge sys_clk or negedge srst_q) begin
        if (!srst_q) begin
            {req_m, req_s, req_p} <= 3'h0;
            ack_tgl_q             <= 1'b0;
            active_q              <= 1'b0;
            wcnt_q                <= '0;
            wr_busy               <= 1'b0;
        end else begin
            {req_m, req_s, req_p} <= {req_tgl_q, req_m, req_s};
            wr_busy <= active_q;
            if (req_ev) begin
                active_q <= 1'b1;
                wcnt_q   <= '0;
            end else if (cyc_end) begin
                active_q  <= 1'b0;
                ack_tgl_q <= ~ack_tgl_q;
            end else if (active_q) begin
                wcnt_q <= wcnt_q + WCW'(1);
            end
        end
    end

    // bank bit tops the nine-bit address
    // page number fixed for the whole copy
    always_ff @(posedge sys_clk) begin
        if (active_q && cmt_op_q == OP_WRITE
            && wcnt_q < WCW'(PAGE_BYTES)
            && mask_q[wcnt_q[PAGE_AW-1:0]]) begin
            mem_q[{cmt_page_q, wcnt_q[PAGE_AW-1:0]}] <=
                pbuf_q[wcnt_q[PAGE_AW-1:0]];
        end
        mem_rd_data <= mem_q[mem_rd_addr];
    end

    // no reset: survives like the cells
    always_ff @(posedge sys_clk) begin
        if (cyc_end && cmt_op_q == OP_SET) begin
            prot_q[cmt_blk_q] <= 1'b1;
        end else if (cyc_end && cmt_op_q == OP_CLR) begin
            prot_q <= '0;
        end
    end

    // ========================================
    // checks
    sequence data_byte_s;
        byte_done && st_q == S_DATA && !prot_s[{bank_q, ptr_q[7]}];
    endsequence

    sequence stop_commit_s;
        stop_det && pend_q != OP_NONE && !busy;
    endsequence

    ptr_wrap_a: assert property (
        @(posedge lnk_clk) disable iff (!lrst_q)
        data_byte_s |=> ptr_q[7:4] == $past(ptr_q[7:4])
            && ptr_q[3:0] == $past(ptr_q[3:0]) + 4'h1)
        else $error("pointer did not step in page");

    word_load_a: assert property (
        @(posedge lnk_clk) disable iff (!lrst_q)
        byte_done && st_q == S_WORD |=> ptr_q == $past(sh_q)
            && sda_oe && st_q == S_DATA)
        else $error("word address not loaded");

    bank_sel_a: assert property (
        @(posedge lnk_clk) disable iff (!lrst_q)
        byte_done && st_q == S_DEV && sh_q[7:1] == 7'h37
            |=> bank_q && sda_oe)
        else $error("bank one select failed");

    bank_query_a: assert property (
        @(posedge lnk_clk) disable iff (!lrst_q)
        byte_done && st_q == S_DEV && sh_q == 8'h6d
            |=> sda_oe == !$past(bank_q))
        else $error("bank query answer wrong");

    prot_nak_a: assert property (
        @(posedge lnk_clk) disable iff (!lrst_q)
        byte_done && st_q == S_DATA && prot_s[{bank_q, ptr_q[7]}]
            |=> (!sda_oe && pend_q == OP_NONE) [*2])
        else $error("protected write accepted");

    set_hv_a: assert property (
        @(posedge lnk_clk) disable iff (!lrst_q)
        byte_done && st_q == S_DEV && sh_q[7:4] == CTL_TYPE
            && blk[2] && !sh_q[0] && !hv_s
            |=> !sda_oe && pend_q != OP_SET)
        else $error("set protect without high voltage");

    stop_commit_a: assert property (
        @(posedge lnk_clk) disable iff (!lrst_q)
        req_tgl_q != $past(req_tgl_q) |-> $past(stop_det))
        else $error("write cycle started without stop");

    commit_go_a: assert property (
        @(posedge lnk_clk) disable iff (!lrst_q)
        stop_commit_s |=> busy ##1 busy)
        else $error("stop did not start write cycle");

    prot_keep_a: assert property (
        @(posedge sys_clk) disable iff (!srst_q)
        (~prot_q & $past(prot_q)) != '0
            |-> $past(cyc_end && cmt_op_q == OP_CLR))
        else $error("protection lost without clear");

endmodule
`default_nettype wire

// >>> bench/ssa_i2c_master.sv
// two-wire bus master model that drives the eeprom link pins
`timescale 1ns/1ps
`default_nettype none
module ssa_i2c_master #(
    parameter int H = 8
)(
    input  wire logic lnk_clk,
    input  wire logic sda_w,
    output logic      scl,
    output logic      sda
);
    // ========================================
    // bus cycles
    // idle bus: both lines released, pull-ups hold them high
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // each line phase lasts H link clocks, well above the sampling needs
    task automatic hold();
        repeat (H) @(posedge lnk_clk);
    endtask

    task automatic start();
        sda <= 1'b1;
        hold();
        sda <= 1'b0;
        hold();
        scl <= 1'b0;
        hold();
    endtask

    task automatic stop();
        sda <= 1'b0;
        hold();
        scl <= 1'b1;
        hold();
        sda <= 1'b1;
        hold();
    endtask

    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            sda <= (i == 0) ? 1'b1 : b[i-1];  // release on the ack slot
            hold();
            scl <= 1'b1;
            hold();
            ack = ~sda_w;                     // low wire means ack
            scl <= 1'b0;
            hold();
        end
    endtask
endmodule
`default_nettype wire

// >>> bench/ssa_spd_eeprom_serial_access_tb_top.sv
// testbench for the spd eeprom two-wire target
`timescale 1ns/1ps
`default_nettype none
module ssa_spd_eeprom_serial_access_tb_top import ssa_pkg::*;;
    // ========================================
    // signals
    logic              sys_clk;
    logic              lnk_clk;
    logic              rst_b;
    logic              hv;
    logic              ap0;
    logic              ap1;
    logic              ap2;
    logic              scl;
    logic              m_sda;
    logic              sda_out;
    logic              sda_oe;
    logic              wr_busy;
    logic [MEM_AW-1:0] rd_addr;
    logic [7:0]        rd_data;
    logic [7:0]        exp_pg [16];
    wire logic         sda_w;
    int                fail_count;
    int                total_checks;

    // open drain wire: anyone pulling low wins over the pull-up
    assign sda_w = m_sda & ~(sda_oe & ~sda_out);

    // ========================================
    // instances
    ssa_spd_eeprom #(.WR_CYC(40)) i_ssa_spd_eeprom (
        .sys_clk(sys_clk), .rst_b(rst_b), .lnk_clk(lnk_clk),
        .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe(sda_oe), .high_voltage_level(hv),
        .addr_pin_zero(ap0), .addr_pin_one(ap1), .addr_pin_two(ap2),
        .mem_rd_addr(rd_addr), .mem_rd_data(rd_data), .wr_busy(wr_busy));

    ssa_i2c_master i_ssa_i2c_master (
        .lnk_clk(lnk_clk), .sda_w(sda_w), .scl(scl), .sda(m_sda));

    // ========================================
    // clocks, link clock offset so the phases are unrelated
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        lnk_clk = 1'b0;
        #7;
        forever #15 lnk_clk = ~lnk_clk;
    end

    // ========================================
    // compare and helper tasks
    task automatic end_sim();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk_bit(input string w, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %b seen %b", w, e, g);
        end
    endtask

    task automatic chk_byte(input string w, input logic [7:0] e,
                            input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic send(input logic [7:0] b, input logic e);
        logic a;
        i_ssa_i2c_master.put_byte(b, a);
        chk_bit($sformatf("ack of %h", b), e, a);
    endtask

    task automatic cmd(input logic [7:0] c, input logic e);
        i_ssa_i2c_master.start();
        send(c, e);
        i_ssa_i2c_master.stop();
    endtask

    // memory address byte follows the strap pins
    function automatic logic [7:0] mad();
        return {MEM_TYPE, ap2, ap1, ap0, 1'b0};
    endfunction

    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        @(posedge sys_clk) rd_addr <= a;
        repeat (2) @(posedge sys_clk);
        #1 chk_byte($sformatf("mem %h", a), e, rd_data);
    endtask

    // bounded wait for a whole internal cycle, a hang ends the run
    task automatic wait_done();
        int n;
        int m;
        for (n = 0; n < 100 && wr_busy !== 1'b1; n++) @(posedge sys_clk);
        for (m = 0; m < 100 && wr_busy !== 1'b0; m++) @(posedge sys_clk);
        chk_bit("write cycle ends", 1'b1, n < 100 && m < 100);
        if (fail_count > 0) end_sim();
        repeat (8) @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] w, input logic [7:0] d);
        i_ssa_i2c_master.start();
        send(mad(), 1'b1);
        send(w, 1'b1);
        send(d, 1'b1);
    endtask

    // ========================================
    // scenarios
    task automatic byte_write();
        wr(8'h13, 8'h5a);                  // inside one page
        chk_bit("busy before stop", 1'b0, wr_busy);
        i_ssa_i2c_master.stop();
        wait_done();
        rd(9'h013, 8'h5a);
    endtask

    task automatic page_wrap();
        wr(8'h2e, 8'h40);
        for (int i = 1; i < 18; i++) send(8'h40 + i[7:0], 1'b1);
        i_ssa_i2c_master.stop();
        wait_done();
        for (int i = 0; i < 18; i++) exp_pg[(14 + i) % 16] = 8'h40 + i[7:0];
        for (int j = 0; j < 16; j++) rd(9'h020 + j[8:0], exp_pg[j]);
    endtask

    task automatic bank_sel();
        @(posedge sys_clk) {ap2, ap1, ap0, hv} <= 4'hb;
        cmd(8'h6e, 1'b1);
        cmd(8'h6d, 1'b0);
        wr(8'h13, 8'ha5);
        i_ssa_i2c_master.stop();
        wait_done();
        rd(9'h113, 8'ha5);
        rd(9'h013, 8'h5a);
        cmd(8'h6c, 1'b1);
        cmd(8'h6d, 1'b1);
        @(posedge sys_clk) {ap2, ap1, ap0, hv} <= 4'h0;
    endtask

    task automatic protect();
        wr(8'h85, 8'h33);
        i_ssa_i2c_master.stop();
        wait_done();
        cmd(8'h61, 1'b1);
        cmd(8'h69, 1'b1);
        cmd(8'h6b, 1'b1);
        cmd(8'h63, 1'b1);
        cmd(8'h68, 1'b0);
        @(posedge sys_clk) hv <= 1'b1;
        i_ssa_i2c_master.start();
        send(8'h68, 1'b1);
        chk_bit("busy before stop", 1'b0, wr_busy);
        i_ssa_i2c_master.stop();
        wait_done();
        cmd(8'h69, 1'b0);
        cmd(8'h61, 1'b1);
        // mid-run reset: protection is nonvolatile, bank returns to zero
        @(posedge sys_clk) rst_b <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (10) @(posedge sys_clk);
        chk_bit("busy after reset", 1'b0, wr_busy);
        cmd(8'h69, 1'b0);
        cmd(8'h6d, 1'b1);
        i_ssa_i2c_master.start();
        send(mad(), 1'b1);
        send(8'h85, 1'b1);
        send(8'hcc, 1'b0);
        i_ssa_i2c_master.stop();
        repeat (100) @(posedge sys_clk);
        rd(9'h085, 8'h33);
        cmd(8'h69, 1'b0);
        cmd(8'h66, 1'b1);
        wait_done();
        cmd(8'h69, 1'b1);
        @(posedge sys_clk) hv <= 1'b0;
    endtask

    // ========================================
    // main sequence
    initial begin
        fail_count = 0;
        total_checks = 0;
        rst_b = 1'b0;
        {ap2, ap1, ap0, hv} = 4'h0;
        rd_addr = '0;
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (10) @(posedge sys_clk);
        byte_write();
        page_wrap();
        bank_sel();
        protect();
        end_sim();
    end
endmodule
`default_nettype wire
